// *** mio_ports.sv ***
// Memory-mapped digital I/O ports behind a classic Wishbone slave.
// Assumes pins are asynchronous and external logic resolves the pin wires.
`timescale 1ns/10ps
`default_nettype none
`include "mio_params.svh"

module mio_ports
  import mio_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output var  logic [31:0] wb_dat_out,
  output var  logic        wb_ack_out,
  input  wire logic [3:0]  first_bidir_port_in,
  output var  logic [3:0]  first_bidir_port_out,
  output var  logic [3:0]  first_bidir_port_oe_n_out,
  input  wire logic [3:0]  second_bidir_port_in,
  output var  logic [3:0]  second_bidir_port_out,
  output var  logic [3:0]  second_bidir_port_oe_n_out,
  input  wire logic [3:0]  input_only_port_in,
  input  wire logic        single_bit_port_in,
  output var  logic        single_bit_port_out,
  output var  logic        single_bit_port_oe_n_out,
  output var  logic        interrupt_shared_pin_out
);

  mio_pin_if pif ();

  logic [3:0]  lat_reg  [4];
  logic [3:0]  lat_next [4];
  logic [7:0]  dira_reg;
  logic [7:0]  dira_next;
  logic [7:0]  dirc_reg;
  logic [7:0]  dirc_next;
  logic [4:0]  bank_reg;
  logic [4:0]  bank_next;
  logic [3:0]  low_reg;
  logic [3:0]  low_next;
  logic        cfg_reg;
  logic        cfg_next;
  logic [3:0]  xch_reg;
  logic [3:0]  xch_next;
  logic        test_reg;
  logic        test_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [3:0]  oe1_n_reg;
  logic [3:0]  oe2_n_reg;
  logic        oe3_n_reg;
  logic        int_reg;

  logic [3:0]  dirp [4];
  logic [3:0]  pinp [4];
  logic [3:0]  view [4];
  logic        nib_ok;
  logic        wr_hit;
  logic [31:0] rd_val;
  mio_port_t   bp;
  logic [1:0]  bb;
  mio_port_t   np;
  mio_bitop_t  bop;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and interrupt noise eliminator.
  mio_pin_sync u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .pins_in   ({single_bit_port_in, input_only_port_in, second_bidir_port_in, first_bidir_port_in}),
    .pif       (pif)
  );

  assign pif.filter_en = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port direction, pin level and software view.
  assign dirp[0] = dira_reg[3:0];
  assign dirp[1] = dira_reg[7:4];
  assign dirp[2] = 4'h0;
  assign dirp[3] = {3'h0, dirc_reg[0]};
  assign pinp[0] = pif.pin_sync[3:0];
  assign pinp[1] = pif.pin_sync[7:4];
  assign pinp[2] = pif.pin_sync[11:8];
  assign pinp[3] = {3'h0, pif.pin_sync[12]};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_view
      assign view[g] = (dirp[g] & lat_reg[g]) | (~dirp[g] & pinp[g]);
    end
  endgenerate

  assign nib_ok = !bank_reg[`MIO_BANK_EN_BIT] || (bank_reg[3:0] == `MIO_BANK_PORTS);
  assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;
  assign np     = mio_port_t'(wb_adr_in[3:2]);
  assign bop    = mio_bitop_t'(wb_dat_in[`MIO_BITOP_OP_LSB +: 3]);
  assign bp     = wb_dat_in[`MIO_BITOP_IND_BIT] ? mio_port_t'(low_reg[`MIO_LOW_PORT_LSB +: 2])
                                               : mio_port_t'(wb_dat_in[`MIO_BITOP_PORT_LSB +: 2]);
  assign bb     = wb_dat_in[`MIO_BITOP_IND_BIT] ? low_reg[`MIO_LOW_BIT_LSB +: 2]
                                               : wb_dat_in[`MIO_BITOP_BIT_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_in)
      `MIO_OFF_PORT0,
      `MIO_OFF_PORT1,
      `MIO_OFF_PORT2,
      `MIO_OFF_FIRST_BIDIR_PORT: begin
        if (nib_ok) begin
          rd_val = {28'h0000000, view[np]};
        end
      end
      `MIO_OFF_DIRA: begin
        rd_val = {24'h000000, dira_reg};
      end
      `MIO_OFF_DIRC: begin
        rd_val = {24'h000000, dirc_reg};
      end
      `MIO_OFF_BANK: begin
        rd_val = {27'h0000000, bank_reg};
      end
      `MIO_OFF_XCH: begin
        rd_val = {28'h0000000, xch_reg};
      end
      `MIO_OFF_BITOP: begin
        rd_val = {31'h00000000, test_reg};
      end
      `MIO_OFF_LOWREG: begin
        rd_val = {28'h0000000, low_reg};
      end
      `MIO_OFF_CFG: begin
        rd_val = {31'h00000000, cfg_reg};
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and register updates; writes act on the acknowledged edge.
  always_comb begin
    lat_next  = lat_reg;
    dira_next = dira_reg;
    dirc_next = dirc_reg;
    bank_next = bank_reg;
    low_next  = low_reg;
    cfg_next  = cfg_reg;
    xch_next  = xch_reg;
    test_next = test_reg;
    ack_next  = wb_cyc_in && wb_stb_in && !ack_reg;
    dat_next  = ack_next ? rd_val : 32'h0000_0000;
    if (wr_hit) begin
      case (wb_adr_in)
        `MIO_OFF_PORT0,
        `MIO_OFF_PORT1,
        `MIO_OFF_FIRST_BIDIR_PORT: begin
          if (nib_ok && wb_sel_in[0]) begin
            lat_next[np] = wb_dat_in[3:0];
          end
        end
        `MIO_OFF_DIRA: begin
          if (wb_sel_in[0]) begin
            dira_next = wb_dat_in[7:0];
          end
        end
        `MIO_OFF_DIRC: begin
          if (wb_sel_in[0]) begin
            dirc_next = wb_dat_in[7:0];
          end
        end
        `MIO_OFF_BANK: begin
          if (wb_sel_in[0]) begin
            bank_next = wb_dat_in[4:0];
          end
        end
        `MIO_OFF_XCH: begin
          if (nib_ok) begin
            xch_next = view[wb_dat_in[`MIO_XCH_PORT_LSB +: 2]];
            if (wb_dat_in[`MIO_XCH_PORT_LSB +: 2] != 2'h2) begin
              lat_next[wb_dat_in[`MIO_XCH_PORT_LSB +: 2]] = wb_dat_in[3:0];
            end
          end
        end
        `MIO_OFF_INC: begin
          if (nib_ok && wb_dat_in[1:0] != 2'h2) begin
            lat_next[wb_dat_in[1:0]] = view[wb_dat_in[1:0]] + 4'h1;
          end
        end
        `MIO_OFF_BITOP: begin
          if (bp != 2'h2 && !(bp == 2'h3 && bb != 2'h0)) begin
            case (bop)
              MIO_BIT_WRITE: begin
                lat_next[bp][bb] = wb_dat_in[`MIO_BITOP_VAL_BIT];
              end
              MIO_BIT_SET: begin
                lat_next[bp][bb] = 1'b1;
              end
              MIO_BIT_CLEAR: begin
                lat_next[bp][bb] = 1'b0;
              end
              MIO_BIT_TEST_CLEAR: begin
                test_next        = view[bp][bb];
                lat_next[bp][bb] = 1'b0;
              end
              MIO_BIT_TEST: begin
                test_next = view[bp][bb];
              end
              default: begin
                test_next = test_reg;
              end
            endcase
          end else if (bp == 2'h2 && bop == MIO_BIT_TEST) begin
            test_next = view[bp][bb];
          end
        end
        `MIO_OFF_LOWREG: begin
          low_next = wb_dat_in[3:0];
        end
        `MIO_OFF_CFG: begin
          cfg_next = wb_dat_in[`MIO_CFG_FILT_BIT];
        end
        default: begin
          cfg_next = cfg_reg;
        end
      endcase
    end
    lat_next[2] = `MIO_RST_LATCH;
    lat_next[3] = {3'h0, lat_next[3][0]};
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        lat_reg[i] <= `MIO_RST_LATCH;
      end
      dira_reg  <= `MIO_RST_DIR;
      dirc_reg  <= `MIO_RST_DIR;
      oe1_n_reg <= 4'hF;
      oe2_n_reg <= 4'hF;
      oe3_n_reg <= 1'b1;
      bank_reg  <= `MIO_RST_BANK;
      low_reg   <= `MIO_RST_LOW;
      cfg_reg   <= 1'b0;
      xch_reg   <= 4'h0;
      test_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      int_reg   <= 1'b0;
    end else begin
      lat_reg   <= lat_next;
      dira_reg  <= dira_next;
      dirc_reg  <= dirc_next;
      oe1_n_reg <= ~dira_next[3:0];
      oe2_n_reg <= ~dira_next[7:4];
      oe3_n_reg <= ~dirc_next[0];
      bank_reg  <= bank_next;
      low_reg   <= low_next;
      cfg_reg   <= cfg_next;
      xch_reg   <= xch_next;
      test_reg  <= test_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      int_reg   <= pif.int_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign wb_ack_out                 = ack_reg;
  assign wb_dat_out                 = dat_reg;
  assign first_bidir_port_out       = lat_reg[0];
  assign first_bidir_port_oe_n_out  = oe1_n_reg;
  assign second_bidir_port_out      = lat_reg[1];
  assign second_bidir_port_oe_n_out = oe2_n_reg;
  assign single_bit_port_out        = lat_reg[3][0];
  assign single_bit_port_oe_n_out   = oe3_n_reg;
  assign interrupt_shared_pin_out   = int_reg;

endmodule

`default_nettype wire

// *** mio_params.svh ***
// Constants for the memory-mapped digital I/O port block.
// Assumes a 32-bit classic Wishbone slave and a 125 MHz clock.
`ifndef MIO_PARAMS_SVH
`define MIO_PARAMS_SVH

`define MIO_CLK_PERIOD_NS   8
`define MIO_ADR_W           8
`define MIO_OFF_PORT0       8'h00
`define MIO_OFF_PORT1       8'h04
`define MIO_OFF_PORT2       8'h08
`define MIO_OFF_FIRST_BIDIR_PORT       8'h0C
`define MIO_OFF_DIRA        8'h10
`define MIO_OFF_DIRC        8'h14
`define MIO_OFF_BANK        8'h18
`define MIO_OFF_XCH         8'h1C
`define MIO_OFF_INC         8'h20
`define MIO_OFF_BITOP       8'h24
`define MIO_OFF_LOWREG      8'h28
`define MIO_OFF_CFG         8'h2C

`define MIO_BANK_EN_BIT     4
`define MIO_BANK_PORTS      4'hF
`define MIO_XCH_PORT_LSB    4
`define MIO_BITOP_OP_LSB    0
`define MIO_BITOP_PORT_LSB  3
`define MIO_BITOP_BIT_LSB   5
`define MIO_BITOP_VAL_BIT   7
`define MIO_BITOP_IND_BIT   8
`define MIO_LOW_PORT_LSB    2
`define MIO_LOW_BIT_LSB     0
`define MIO_CFG_FILT_BIT    0

`define MIO_RST_LATCH       4'h0
`define MIO_RST_DIR         8'h00
`define MIO_RST_BANK        5'h00
`define MIO_RST_LOW         4'h0

`define MIO_NOISE_NS        100
`define MIO_NOISE_CYC       ((`MIO_NOISE_NS + `MIO_CLK_PERIOD_NS - 1) / `MIO_CLK_PERIOD_NS)
`define MIO_INT_PIN         5
`define MIO_NPINS           13

`endif

// *** mio_pkg.sv ***
// Types shared by the I/O port block modules.
// Assumes mio_params.svh supplies the numeric constants.
`default_nettype none

package mio_pkg;

  typedef enum logic [2:0] {
    MIO_BIT_WRITE,
    MIO_BIT_SET,
    MIO_BIT_CLEAR,
    MIO_BIT_TEST_CLEAR,
    MIO_BIT_TEST
  } mio_bitop_t;

  typedef logic [1:0] mio_port_t;

endpackage

`default_nettype wire

// *** mio_pin_if.sv ***
// Carrier between the port core and its pin synchroniser.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface mio_pin_if;
  logic [12:0] pin_sync;
  logic        int_level;
  logic        filter_en;

  modport syncer (
    output pin_sync,
    output int_level,
    input  filter_en
  );

  modport core (
    input  pin_sync,
    input  int_level,
    output filter_en
  );
endinterface

`default_nettype wire

// *** mio_pin_sync.sv ***
// Synchronises the port pins and filters the shared interrupt pin.
// Assumes pins are asynchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "mio_params.svh"

module mio_pin_sync
  import mio_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [12:0] pins_in,
  mio_pin_if.syncer        pif
);

  logic [12:0] s1_reg;
  logic [12:0] s2_reg;
  logic [12:0] s3_reg;
  logic [12:0] val_reg;
  logic [12:0] val_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic        int_reg;
  logic        int_next;

  ////////////////////////////////////////////////////////////////////////////
  // A pin change counts once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < `MIO_NPINS; g++) begin : g_pin
      assign val_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : val_reg[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // The interrupt pin follows directly or after a stable interval.
  always_comb begin
    cnt_next = 8'h00;
    int_next = int_reg;
    if (!pif.filter_en) begin
      int_next = val_reg[`MIO_INT_PIN];
    end else if (val_reg[`MIO_INT_PIN] != int_reg) begin
      cnt_next = cnt_reg + 8'h01;
      if (cnt_reg >= 8'(`MIO_NOISE_CYC - 1)) begin
        int_next = val_reg[`MIO_INT_PIN];
        cnt_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg  <= 13'h0000;
      s2_reg  <= 13'h0000;
      s3_reg  <= 13'h0000;
      val_reg <= 13'h0000;
      cnt_reg <= 8'h00;
      int_reg <= 1'b0;
    end else begin
      s1_reg  <= pins_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      val_reg <= val_next;
      cnt_reg <= cnt_next;
      int_reg <= int_next;
    end
  end

  assign pif.pin_sync  = val_reg;
  assign pif.int_level = int_reg;

endmodule

`default_nettype wire

// *** mio_pin_model.sv ***
// Model of the circuitry outside the port pins.
// Assumes the bench sets the level that outside logic puts on released pins.
`timescale 1ns/10ps
`default_nettype none

module mio_pin_model (
  input  wire logic [3:0] first_bidir_port_out,
  input  wire logic [3:0] first_bidir_port_oe_n_out,
  input  wire logic [3:0] second_bidir_port_out,
  input  wire logic [3:0] second_bidir_port_oe_n_out,
  input  wire logic       single_bit_port_out,
  input  wire logic       single_bit_port_oe_n_out,
  input  wire logic [3:0] ext0,
  input  wire logic [3:0] ext1,
  input  wire logic [3:0] ext2,
  input  wire logic       ext3,
  output wire logic [3:0] first_bidir_port_in,
  output wire logic [3:0] second_bidir_port_in,
  output wire logic [3:0] input_only_port_in,
  output wire logic       single_bit_port_in
);
  // A driven pin shows the latch, a released pin the outside level.
  assign first_bidir_port_in  = (first_bidir_port_oe_n_out & ext0) |
                                (~first_bidir_port_oe_n_out & first_bidir_port_out);
  assign second_bidir_port_in = (second_bidir_port_oe_n_out & ext1) |
                                (~second_bidir_port_oe_n_out & second_bidir_port_out);
  assign single_bit_port_in   = single_bit_port_oe_n_out ? ext3 : single_bit_port_out;
  assign input_only_port_in   = ext2;
endmodule

`default_nettype wire

// *** mio_ports_asserts.sv ***
// Checker for the bus answer and the pin drive of the port block.
// Assumes it is bound to mio_ports and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module mio_ports_asserts (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [31:0] wb_dat_out,
  input  wire logic        wb_ack_out,
  input  wire logic [3:0]  first_bidir_port_out,
  input  wire logic [3:0]  first_bidir_port_oe_n_out,
  input  wire logic [3:0]  second_bidir_port_oe_n_out,
  input  wire logic        single_bit_port_out,
  input  wire logic        single_bit_port_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  logic       wr_take;
  logic       blk_reg;
  logic [7:0] dira_reg;
  logic       dirc_reg;
  logic [3:0] p0_reg;
  assign wr_take = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blk_reg  <= 1'b0;
      dira_reg <= 8'h00;
      dirc_reg <= 1'b0;
      p0_reg   <= 4'h0;
    end else if (wr_take) begin
      if (wb_adr_in == 8'h18) blk_reg <= wb_dat_in[4] && (wb_dat_in[3:0] != 4'hF);
      if (wb_adr_in == 8'h10) dira_reg <= wb_dat_in[7:0];
      if (wb_adr_in == 8'h14) dirc_reg <= wb_dat_in[0];
      if (wb_adr_in == 8'h00) p0_reg <= wb_dat_in[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  ack_single_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data without ack");
  reset_clear_a: assert property ($rose(arst_n_in) |-> first_bidir_port_oe_n_out == 4'hF &&
    second_bidir_port_oe_n_out == 4'hF && single_bit_port_oe_n_out && first_bidir_port_out == 4'h0)
    else $error("pins not released after reset");
  dira_apply_a: assert property (wr_take && wb_adr_in == 8'h10 |-> ##2
    {second_bidir_port_oe_n_out, first_bidir_port_oe_n_out} == ~dira_reg) else $error("group a drive wrong");
  dirc_apply_a: assert property (wr_take && wb_adr_in == 8'h14 |-> ##2 single_bit_port_oe_n_out == !dirc_reg)
    else $error("group c drive wrong");
  dir_byte_a: assert property (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && !wb_sel_in[0] &&
    wb_adr_in == 8'h10 |=> $stable(first_bidir_port_oe_n_out) [*2]) else $error("partial direction write");
  port_write_a: assert property (wr_take && wb_adr_in == 8'h00 && !blk_reg |-> ##2
    first_bidir_port_out == p0_reg) else $error("port latch not written");
  cover property (wr_take && wb_adr_in == 8'h10);
  cover property (wr_take && blk_reg && wb_adr_in == 8'h00);
  cover property (!single_bit_port_oe_n_out && single_bit_port_out);
endmodule

bind mio_ports mio_ports_asserts u_chk (.*);

`default_nettype wire

// *** memory_mapped_digital_io_ports_bench.sv ***
// Self-checking bench for the memory-mapped I/O port block.
// Assumes mio_pin_model stands on the pins and the bench drives the bus.
`timescale 1ns/10ps
`default_nettype none

module memory_mapped_digital_io_ports_bench;
  import mio_pkg::*;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0, ext0 = 4'h5, ext1 = 4'hE, ext2 = 4'h9;
  logic        ext3 = 1'b0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic        wb_ack_out, single_bit_port_out, single_bit_port_oe_n_out, interrupt_shared_pin_out;
  logic [3:0]  first_bidir_port_out, first_bidir_port_oe_n_out, second_bidir_port_out, second_bidir_port_oe_n_out;
  wire  logic [3:0] first_bidir_port_in, second_bidir_port_in, input_only_port_in;
  wire  logic       single_bit_port_in;
  int          fails = 0, cmp_count = 0;
  mio_bitop_t  ops [5] = '{MIO_BIT_WRITE, MIO_BIT_CLEAR, MIO_BIT_SET, MIO_BIT_TEST_CLEAR, MIO_BIT_TEST};
  logic [31:0] r;

  mio_ports uut (.*);
  mio_pin_model pins (.*);
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= s;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 40);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 40) fails++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk($sformatf("read %h", a), q, e);
  endtask
  task automatic pins_idle;
    chk("drive", {first_bidir_port_oe_n_out, second_bidir_port_oe_n_out, single_bit_port_oe_n_out}, 32'h1FF);
    chk("latch", {first_bidir_port_out, second_bidir_port_out, single_bit_port_out}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    pins_idle();
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h00, 32'h5);
    rd(8'h08, 32'h9);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h9);
    chk("irq", interrupt_shared_pin_out, 32'h1);
    wr(8'h2C, 32'h1);
    @(posedge clk_in);
    ext1 <= 4'hC;
    repeat (8) @(negedge clk_in);
    chk("irq held", interrupt_shared_pin_out, 32'h1);
    repeat (20) @(negedge clk_in);
    chk("irq late", interrupt_shared_pin_out, 32'h0);
    wr(8'h00, 32'hA);
    chk("p0 latch", {first_bidir_port_oe_n_out, first_bidir_port_out}, 32'hFA);
    rd(8'h00, 32'h5);
    wr(8'h10, 32'h3C, 4'hE);
    chk("p0 drive", first_bidir_port_oe_n_out, 32'hF);
    wr(8'h10, 32'h3C);
    chk("a drive", {second_bidir_port_oe_n_out, first_bidir_port_oe_n_out}, 32'hC3);
    rd(8'h00, 32'h9);
    rd(8'h10, 32'h3C);
    wr(8'h00, 32'h6);
    chk("p0 out", first_bidir_port_out, 32'h6);
    @(posedge clk_in);
    ext0 <= 4'h3;
    repeat (8) @(posedge clk_in);
    wr(8'h20, 32'h0);
    chk("inc", first_bidir_port_out, 32'h8);
    wr(8'h1C, 32'h19);
    chk("xch latch", second_bidir_port_out, 32'h9);
    rd(8'h1C, 32'hC);
    wr(8'h18, 32'h13);
    wr(8'h00, 32'hF);
    chk("blocked", first_bidir_port_out, 32'h8);
    rd(8'h00, 32'h0);
    wr(8'h14, 32'h1);
    chk("c drive", single_bit_port_oe_n_out, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h24, {23'h0, 1'b0, i == 0, 4'b0011, ops[i]});
      chk("bit latch", single_bit_port_out, (i == 0 || i == 2) ? 32'h1 : 32'h0);
      if (i > 2) begin
        bus(1'b0, 8'h24, 32'h0, 4'hF, r);
        chk("bit test", r[0], (i == 3) ? 32'h1 : 32'h0);
      end
    end
    wr(8'h28, 32'h1);
    wr(8'h24, {23'h0, 9'h100} | MIO_BIT_SET);
    chk("indirect", first_bidir_port_out, 32'hA);
    wr(8'h18, 32'h1F);
    wr(8'h00, 32'h5);
    chk("bank 15", first_bidir_port_out, 32'h5);
    wr(8'h04, 32'h7);
    chk("p1 out", second_bidir_port_out, 32'h7);
    wr(8'h0C, 32'hF);
    chk("p3 out", single_bit_port_out, 32'h1);
    rd(8'h0C, 32'h1);
    wr(8'h24, 32'h14);
    rd(8'h24, 32'h1);
    rd(8'h3C, 32'h0);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    @(negedge clk_in);
    pins_idle();
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(8'h10, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
